// >>> gauge_remote_control.sv
// ion gauge and degas on/off control with remote inputs and relays
//
// How it works
// - gauge on/off comes from keys, remote inputs, auto-on and host commands
// - each gauge key press toggles that gauge
// - both gauges never on; turning one on turns the other off
// - degas on/off comes from key, remote input and host commands
// - each degas key press toggles degas
// - degas refused to start unless gauge pressure is below threshold
// - remote inputs are active low and act like the panel keys
// - gauge and degas remote lows must last 25 ms to count
// - after reset or a counted low, input must stay high 105 ms before another low counts
// - key inhibit held low disables all panel keys
// - lockout held low rejects gauge turn-on from panel and host
// - lockout asserted while a gauge is on turns it off
// - one filament relay per gauge, energised while gauge is on
// - fault relay contact opens when a fault is indicated
// - jumper selects fault status or degas status on fault relay
// - with jumper at fault status, fault relay energised only while no fault is detected
`timescale 1ns/10ps
`default_nettype none
module gauge_remote_control
#(
    parameter int TICK_CYCLES = gauge_remote_pkg::TICK_CYCLES,
    parameter int LOW_MS      = gauge_remote_pkg::REMOTE_LOW_MS,
    parameter int HIGH_MS     = gauge_remote_pkg::REMOTE_HIGH_MS
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // front-panel key presses, one-cycle pulses from keypad logic
    input  wire logic firstGaugeKey,
    input  wire logic secondGaugeKey,
    input  wire logic degasKey,
    // rear-panel remote pins, active low, asynchronous
    input  wire logic keyInhibitN,
    input  wire logic degasRemoteN,
    input  wire logic firstGaugeRemoteN,
    input  wire logic secondGaugeRemoteN,
    input  wire logic gaugeLockoutN,
    // gauge module auto-on requests, pulses
    input  wire logic autoFirstOn,
    input  wire logic autoFirstOff,
    input  wire logic autoSecondOn,
    input  wire logic autoSecondOff,
    // computer interface commands, pulses
    input  wire logic hostFirstOn,
    input  wire logic hostFirstOff,
    input  wire logic hostSecondOn,
    input  wire logic hostSecondOff,
    input  wire logic hostDegasOn,
    input  wire logic hostDegasOff,
    // pressure and fault status from the measurement logic
    input  wire logic pressureLowEnough,
    input  wire logic faultDetected,
    // configuration jumper, high selects degas status
    input  wire logic relaySourceJumper,
    // state and relay drives
    output logic      firstGaugeOn,
    output logic      secondGaugeOn,
    output logic      degasOn,
    output logic      firstFilamentRelay,
    output logic      secondFilamentRelay,
    output logic      faultRelay
);
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NPIN        = 5;
    // positions of the pins in the synchroniser vector
    localparam int PIN_INHIBIT = 0;
    localparam int PIN_DEGAS   = 1;
    localparam int PIN_FIRST   = 2;
    localparam int PIN_SECOND  = 3;
    localparam int PIN_LOCKOUT = 4;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinMeta_q;
    logic [NPIN-1:0] pinSync_q;

    assign pinRaw = {gaugeLockoutN, secondGaugeRemoteN,
                     firstGaugeRemoteN, degasRemoteN, keyInhibitN};

    // idle pins read high so nothing is asserted out of reset
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pinMeta_q <= '1;
            pinSync_q <= '1;
        end
        else
        begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
        end
    end

    // levels, not edges: both act for as long as the pin is held low
    wire keysInhibited = ~pinSync_q[PIN_INHIBIT];
    wire lockout       = ~pinSync_q[PIN_LOCKOUT];

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    logic [TICK_W-1:0] tickCnt_q;
    logic              msTick_q;
    wire               tickWrap = tickCnt_q == TICK_W'(TICK_CYCLES - 1);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            tickCnt_q <= '0;
            msTick_q  <= 1'b0;
        end
        else
        begin
            tickCnt_q <= tickWrap ? '0 : tickCnt_q + 1'b1;
            msTick_q  <= tickWrap;
        end
    end

    // ------------------------------------------------------------
    // remote input qualification
    // ------------------------------------------------------------
    logic [2:0] remoteFire;

    // qualifiers serve degas, first and second gauge in pin order
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_remote
            remote_input_qualifier
            #(
                .LOW_MS  (LOW_MS),
                .HIGH_MS (HIGH_MS)
            )
            u_qual
            (
                .clk     (clk),
                .rstn    (rstn),
                .msTick  (msTick_q),
                .inN     (pinSync_q[PIN_DEGAS + gi]),
                .fire    (remoteFire[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // keys gated by inhibit; remote pins are not keys, so still act
    wire keyFirst  = firstGaugeKey  & ~keysInhibited;
    wire keySecond = secondGaugeKey & ~keysInhibited;
    wire keyDegas  = degasKey       & ~keysInhibited;

    // toggles from key or qualified remote low
    wire togFirst  = keyFirst  | remoteFire[1];
    wire togSecond = keySecond | remoteFire[2];
    wire togDegas  = keyDegas  | remoteFire[0];

    // explicit commands; unlike keys they never toggle
    wire cmdFirstOn   = autoFirstOn   | hostFirstOn;
    wire cmdFirstOff  = autoFirstOff  | hostFirstOff;
    wire cmdSecondOn  = autoSecondOn  | hostSecondOn;
    wire cmdSecondOff = autoSecondOff | hostSecondOff;

    logic gauge1_q;
    logic gauge2_q;
    logic degas_q;

    // ------------------------------------------------------------
    // gauge state
    // ------------------------------------------------------------
    // a toggle asks for the opposite of the present state
    function automatic logic toggleTo(input logic tog,
                                      input logic cur,
                                      input logic wantOn);
        toggleTo = tog & (cur != wantOn);
    endfunction

    // on/off requests per gauge from all four sources
    wire onReq1  = toggleTo(togFirst, gauge1_q, 1'b1) | cmdFirstOn;
    wire offReq1 = toggleTo(togFirst, gauge1_q, 1'b0) | cmdFirstOff;
    wire onReq2  = toggleTo(togSecond, gauge2_q, 1'b1) | cmdSecondOn;
    wire offReq2 = toggleTo(togSecond, gauge2_q, 1'b0) | cmdSecondOff;

    // lockout passes the synchroniser, so it bites two to three cycles
    // after the pin falls; a request inside that gap still acts once
    // turn-on refused under lockout; first gauge wins a tie
    wire turnOn1 = onReq1 & ~lockout;
    wire turnOn2 = onReq2 & ~lockout & ~turnOn1;

    function automatic logic nextGauge(input logic cur,
                                       input logic on,
                                       input logic off,
                                       input logic otherOn,
                                       input logic lock);
        if (lock)
            nextGauge = 1'b0;
        else if (on)
            nextGauge = 1'b1;
        else if (off || otherOn)
            nextGauge = 1'b0;
        else
            nextGauge = cur;
    endfunction

    // lockout forces both off; an on forces the other off
    wire gauge1_d = nextGauge(gauge1_q, turnOn1, offReq1,
                              turnOn2, lockout);
    wire gauge2_d = nextGauge(gauge2_q, turnOn2, offReq2,
                              turnOn1, lockout);

    // ------------------------------------------------------------
    // degas state
    // ------------------------------------------------------------
    // stopping is always allowed; only a start checks the pressure
    wire degasOnReq  = toggleTo(togDegas, degas_q, 1'b1)
                     | hostDegasOn;
    wire degasOffReq = toggleTo(togDegas, degas_q, 1'b0)
                     | hostDegasOff;
    wire degasStart  = degasOnReq & pressureLowEnough;

    // degas has no gauge to heat once both are off
    wire anyGaugeOn_d = gauge1_d | gauge2_d;
    wire degas_d      = ~anyGaugeOn_d ? 1'b0
                      : degasOffReq   ? 1'b0
                      : degasStart    ? 1'b1
                      : degas_q;

    // ------------------------------------------------------------
    // relay selection
    // ------------------------------------------------------------
    // energised relay closes normally-open contact
    wire faultRelay_d = (relaySourceJumper == gauge_remote_pkg::JUMPER_DEGAS)
                      ? degas_d
                      : ~faultDetected;

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            gauge1_q <= gauge_remote_pkg::GAUGE_RST;
            gauge2_q <= gauge_remote_pkg::GAUGE_RST;
            degas_q  <= gauge_remote_pkg::DEGAS_RST;
        end
        else
        begin
            gauge1_q <= gauge1_d;
            gauge2_q <= gauge2_d;
            degas_q  <= degas_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // state outputs registered alongside state, on the same edge
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            firstGaugeOn  <= 1'b0;
            secondGaugeOn <= 1'b0;
            degasOn       <= 1'b0;
        end
        else
        begin
            firstGaugeOn  <= gauge1_d;
            secondGaugeOn <= gauge2_d;
            degasOn       <= degas_d;
        end
    end

    // relays drop out in reset, so a held reset reads as a fault
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            firstFilamentRelay  <= 1'b0;
            secondFilamentRelay <= 1'b0;
            faultRelay          <= 1'b0;
        end
        else
        begin
            firstFilamentRelay  <= gauge1_d;
            secondFilamentRelay <= gauge2_d;
            faultRelay          <= faultRelay_d;
        end
    end
endmodule
`default_nettype wire

// >>> gauge_remote_pkg.sv
// constants shared by the gauge remote control block
package gauge_remote_pkg;
    // clock and time base
    localparam int CLK_HZ          = 25000000;
    localparam int MS_PER_S        = 1000;
    localparam int TICK_CYCLES     = CLK_HZ / MS_PER_S;
    // remote input timing in milliseconds, and qualifier counter width
    localparam int REMOTE_LOW_MS   = 25;
    localparam int REMOTE_HIGH_MS  = 105;
    localparam int MS_CNT_W        = 8;
    // reset values
    localparam logic GAUGE_RST     = 1'b0;
    localparam logic DEGAS_RST     = 1'b0;
    // jumper selection of the fault relay source
    localparam logic JUMPER_FAULT  = 1'b0;
    localparam logic JUMPER_DEGAS  = 1'b1;
endpackage

// >>> remote_input_qualifier.sv
// qualifies one active-low remote input by minimum low and high times
`timescale 1ns/10ps
`default_nettype none
module remote_input_qualifier
#(
    parameter int LOW_MS  = gauge_remote_pkg::REMOTE_LOW_MS,
    parameter int HIGH_MS = gauge_remote_pkg::REMOTE_HIGH_MS,
    parameter int CNT_W   = gauge_remote_pkg::MS_CNT_W
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // time base
    input  wire logic msTick,
    // synchronised input, low when asserted
    input  wire logic inN,
    // one-cycle pulse per qualified low
    output logic      fire
);
    typedef enum {WAIT_HIGH, ARMED, LOW_SEEN, DONE_LOW} qual_t;

    qual_t            state_q;
    qual_t            state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             fire_d;

    // one tick more than the minimum, as the first tick is partial
    localparam int LOW_TICKS  = LOW_MS + 1;
    localparam int HIGH_TICKS = HIGH_MS + 1;

    // ------------------------------------------------------------
    // qualification sequence
    // ------------------------------------------------------------
    // counts are in whole ticks; the first partial tick is not
    // credited, so a low must span LOW_MS full ticks
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        fire_d  = 1'b0;
        case (state_q)
            WAIT_HIGH:
            begin
                if (inN == 1'b0)
                    cnt_d = '0;
                else if (msTick && cnt_q != CNT_W'(HIGH_TICKS))
                    cnt_d = cnt_q + 1'b1;
                if (inN && cnt_q == CNT_W'(HIGH_TICKS))
                    state_d = ARMED;
            end
            ARMED:
            begin
                cnt_d = '0;
                if (inN == 1'b0)
                    state_d = LOW_SEEN;
            end
            LOW_SEEN:
            begin
                if (inN)
                begin
                    state_d = ARMED; // short low ignored
                    cnt_d   = '0;
                end
                else if (cnt_q == CNT_W'(LOW_TICKS))
                begin
                    fire_d  = 1'b1; // one action per low
                    state_d = DONE_LOW;
                end
                else if (msTick)
                    cnt_d = cnt_q + 1'b1;
            end
            DONE_LOW:
            begin
                cnt_d = '0;
                if (inN)
                    state_d = WAIT_HIGH;
            end
            default:
            begin
                state_d = WAIT_HIGH;
                cnt_d   = '0;
            end
        endcase
    end

    // waits for a full high time after reset too, so a line held low
    // at power-up does not fire
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_q <= WAIT_HIGH;
            cnt_q   <= '0;
            fire    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            fire    <= fire_d;
        end
    end
endmodule
`default_nettype wire

// >>> remote_contact_model.sv
// contact closure model driving the rear-panel remote pins
`timescale 1ns/10ps
`default_nettype none
module remote_contact_model
(
    // closures: inhibit, degas, first, second, lockout
    input  wire logic [4:0] close,
    // pin levels seen by the block
    output wire logic [4:0] pinN
);
    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // open contacts leave the pull-ups in charge, never a stale level
    assign pinN = ~close;
endmodule
`default_nettype wire

// >>> gauge_remote_control_assertions.sv
// concurrent checks on the gauge remote control ports
`timescale 1ns/10ps
`default_nettype none
module gauge_remote_control_assertions
#(
    parameter int TICK_CYCLES = gauge_remote_pkg::TICK_CYCLES,
    parameter int LOW_MS      = gauge_remote_pkg::REMOTE_LOW_MS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // requests and pins
    input wire logic firstGaugeKey,
    input wire logic degasKey,
    input wire logic keyInhibitN,
    input wire logic firstGaugeRemoteN,
    input wire logic gaugeLockoutN,
    input wire logic autoFirstOn,
    input wire logic autoFirstOff,
    input wire logic hostFirstOn,
    input wire logic hostFirstOff,
    input wire logic pressureLowEnough,
    input wire logic faultDetected,
    input wire logic relaySourceJumper,
    // state and relays
    input wire logic firstGaugeOn,
    input wire logic secondGaugeOn,
    input wire logic degasOn,
    input wire logic firstFilamentRelay,
    input wire logic secondFilamentRelay,
    input wire logic faultRelay
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic        prevPin_q;
    logic [15:0] lowRun_q;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // length of the latest low run, kept after release for late fires
    always_ff @(posedge clk)
    begin
        prevPin_q <= firstGaugeRemoteN;
        if (!rstn)
            lowRun_q <= 16'h0;
        else if (!firstGaugeRemoteN)
            lowRun_q <= prevPin_q ? 16'h1 : lowRun_q + 16'h1;
    end
    a_never_both: assert property (!(firstGaugeOn && secondGaugeOn))
        else $error("both gauges on");
    a_relays_follow: assert property (
        firstFilamentRelay == firstGaugeOn
        && secondFilamentRelay == secondGaugeOn)
        else $error("filament relay mismatch");
    a_fault_shown: assert property (
        !relaySourceJumper && !$past(relaySourceJumper) && $past(rstn)
        |-> faultRelay == !$past(faultDetected))
        else $error("fault relay wrong");
    a_degas_shown: assert property (
        relaySourceJumper && $past(relaySourceJumper) && $stable(degasOn)
        && $past(rstn) |-> faultRelay == degasOn)
        else $error("degas status relay wrong");
    a_lockout_off: assert property (
        !gaugeLockoutN [*5] |-> !firstGaugeOn && !secondGaugeOn && !degasOn)
        else $error("gauge on under lockout");
    a_degas_gate: assert property (
        $rose(degasOn) |-> $past(pressureLowEnough))
        else $error("degas started at high pressure");
    a_key_toggles: assert property (
        firstGaugeKey && !firstGaugeOn && keyInhibitN
        && $past(keyInhibitN, 3) && gaugeLockoutN && $past(gaugeLockoutN, 3)
        && !hostFirstOff && !autoFirstOff |=> firstGaugeOn)
        else $error("key did not turn gauge on");
    a_key_inhibit: assert property (
        firstGaugeKey && !firstGaugeOn && !keyInhibitN
        && !$past(keyInhibitN, 2) && !hostFirstOn && !autoFirstOn
        |=> !firstGaugeOn)
        else $error("inhibited key acted");
    a_degas_toggle: assert property (
        degasKey && degasOn && keyInhibitN && $past(keyInhibitN, 3)
        |=> !degasOn)
        else $error("degas key did not turn degas off");
    a_remote_low: assert property (
        $rose(firstGaugeOn) && !$past(firstGaugeKey) && !$past(hostFirstOn)
        && !$past(autoFirstOn) |-> lowRun_q >= 16'(LOW_MS * TICK_CYCLES))
        else $error("remote low too short");
    c_first_on: cover property ($rose(firstGaugeOn));
    c_degas_on: cover property ($rose(degasOn));
    c_fault_drop: cover property ($fell(faultRelay));
endmodule
bind gauge_remote_control gauge_remote_control_assertions
    #(.TICK_CYCLES(TICK_CYCLES), .LOW_MS(LOW_MS)) i_checker (.*);
`default_nettype wire

// >>> gauge_remote_control_test.sv
// self-checking bench for the gauge remote control block
`timescale 1ns/10ps
`default_nettype none
module gauge_remote_control_test;
    logic            clk      = 1'b0;
    logic            rstn     = 1'b0;
    logic [12:0]     req      = 13'h0;
    logic [4:0]      close    = 5'h0;
    logic            pressure = 1'b1;
    logic            fault    = 1'b0;
    logic            jumper   = 1'b0;
    wire logic [4:0] pinN;
    wire logic [5:0] st;
    int              errors   = 0;
    int              compares = 0;
    int              cyc      = 0;
    int              onIdx[4] = '{7, 3, 5, 9};
    always #20 clk = ~clk;
    remote_contact_model i_remote_contact_model (.close(close), .pinN(pinN));
    gauge_remote_control #(.TICK_CYCLES(4), .LOW_MS(3), .HIGH_MS(5))
    i_gauge_remote_control
    (
        .clk(clk), .rstn(rstn), .firstGaugeKey(req[0]), .secondGaugeKey(req[1]),
        .degasKey(req[2]), .autoFirstOn(req[3]), .autoFirstOff(req[4]),
        .autoSecondOn(req[5]), .autoSecondOff(req[6]), .hostFirstOn(req[7]),
        .hostFirstOff(req[8]), .hostSecondOn(req[9]), .hostSecondOff(req[10]),
        .hostDegasOn(req[11]), .hostDegasOff(req[12]), .keyInhibitN(pinN[0]),
        .degasRemoteN(pinN[1]), .firstGaugeRemoteN(pinN[2]),
        .secondGaugeRemoteN(pinN[3]), .gaugeLockoutN(pinN[4]),
        .pressureLowEnough(pressure), .faultDetected(fault),
        .relaySourceJumper(jumper), .firstGaugeOn(st[5]), .secondGaugeOn(st[4]),
        .degasOn(st[3]), .firstFilamentRelay(st[2]),
        .secondFilamentRelay(st[1]), .faultRelay(st[0])
    );
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // e is first, second, degas; relays derive from it, the jumper and fault
    task automatic chk(input logic [2:0] e);
        logic [5:0] exp;
        exp = {e, e[2], e[1], jumper ? e[0] : ~fault};
        compares++;
        if (st !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, st, exp);
        end
    endtask
    // one-cycle request, answer checked one cycle after it is taken
    task automatic act(input int b, input logic [2:0] e);
        @(negedge clk);
        req[b] = 1'b1;
        @(negedge clk);
        req[b] = 1'b0;
        @(negedge clk);
        chk(e);
    endtask
    // closure of n cycles, then gap cycles open before checking
    task automatic rem(input int b, input int n, input int gap,
                       input logic [2:0] e);
        @(negedge clk);
        close[b] = 1'b1;
        repeat (n) @(negedge clk);
        close[b] = 1'b0;
        repeat (gap) @(negedge clk);
        chk(e);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    // the whole run takes about 600 cycles, so 3000 means a hang
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        act(0, 3'b100);
        act(1, 3'b010);
        act(2, 3'b011);
        act(2, 3'b010);
        pressure = 1'b0;
        act(11, 3'b010);
        pressure = 1'b1;
        act(11, 3'b011);
        act(12, 3'b010);
        for (int i = 0; i < 4; i++)
        begin
            act(onIdx[i], i < 2 ? 3'b100 : 3'b010);
            act(onIdx[i] + 1, 3'b000);
        end
        close[0] = 1'b1;
        repeat (4) @(negedge clk);
        act(0, 3'b000);
        close[0] = 1'b0;
        repeat (4) @(negedge clk);
        act(0, 3'b100);
        jumper = 1'b1;
        act(2, 3'b101);
        jumper = 1'b0;
        fault = 1'b1;
        repeat (2) @(negedge clk);
        chk(3'b101);
        fault = 1'b0;
        close[4] = 1'b1;
        repeat (5) @(negedge clk);
        chk(3'b000);
        act(7, 3'b000);
        act(0, 3'b000);
        close[4] = 1'b0;
        repeat (4) @(negedge clk);
        rem(2, 6, 40, 3'b000);
        rem(2, 11, 40, 3'b000);
        rem(2, 30, 10, 3'b100);
        rem(2, 30, 40, 3'b100);
        rem(2, 30, 40, 3'b000);
        act(0, 3'b100);
        rem(1, 30, 40, 3'b101);
        rem(1, 30, 40, 3'b100);
        rem(3, 30, 40, 3'b010);
        tally_and_finish();
    end
endmodule
`default_nettype wire
